// >>> verilog/flash_host_regs.svh
`ifndef FLASH_HOST_REGS_SVH
`define FLASH_HOST_REGS_SVH

// pin positions on the flash address bus
`define ADDR_W            20
`define ID_BYTE_BIT       0
`define QUERY_BIT         1
`define AUX_BIT           6
`define GRP_LSB           17
`define GRP_W             3
`define PARITY_BIT        7

// low address pattern for protection verify and autoselect group status
`define VERIFY_LOW_ADDR   20'h00002
`define PROT_FLAG_BIT     0

// timing
`define CLK_PERIOD_NS     10
`define WAKE_NS           500
`define WAKE_CYC          ((`WAKE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SETUP_CYC_DEF     2
`define ACCESS_CYC_DEF    10
`define WE_CYC_DEF        5
`define PROT_CYC_DEF      1000
`define HOLD_CYC_DEF      2

`endif

// >>> verilog/flash_host_pkg.sv
package flash_host_pkg;

    // requests accepted on the user command port
    typedef enum logic [2:0] {
        OP_READ,
        OP_WRITE,
        OP_ID_HW,
        OP_PROT_SET,
        OP_PROT_CHECK,
        OP_SLEEP,
        OP_WAKE
    } op_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SETUP,
        ST_STROBE,
        ST_HOLD,
        ST_WAKE
    } seq_t;

    typedef struct packed {
        seq_t        st;
        op_t         op;
        logic        asleep;
        logic [19:0] addr;
        logic [7:0]  wdata;
        logic        ce_n;
        logic        oe_n;
        logic        we_n;
        logic        dev_rst_n;
        logic        dq_oe;
        logic        hv_line;
        logic        hv_oe;
        logic        rsp_valid;
        logic        rsp_err;
        logic [7:0]  rsp_data;
    } host_state_t;

    typedef struct packed {
        logic [15:0] cnt;
        logic        done;
    } timer_state_t;

endpackage : flash_host_pkg

// >>> verilog/seq_timer_if.sv
`timescale 1ns/1ns
interface seq_timer_if #(parameter int CW = 16);
    logic          start;
    logic [CW-1:0] load;
    logic          done;
    modport ctl (output start, output load, input done);
    modport tmr (input start, input load, output done);
endinterface : seq_timer_if

// >>> verilog/seq_timer.sv
`timescale 1ns/1ns
module seq_timer
    import flash_host_pkg::*;
(
    input  wire logic clk,
    input  wire logic nrst,
    seq_timer_if.tmr  tif
);
    timer_state_t t_r;
    timer_state_t t_nxt;

    // load on start, count down, pulse done as the count reaches zero
    always_comb begin
        t_nxt      = t_r;
        t_nxt.done = 1'b0;
        if (tif.start) begin
            t_nxt.cnt = tif.load;
        end else if (t_r.cnt != 16'h0000) begin
            t_nxt.cnt = t_r.cnt - 16'h0001;
            if (t_r.cnt == 16'h0001) begin
                t_nxt.done = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            t_r <= '0;
        end else begin
            t_r <= t_nxt;
        end
    end

    assign tif.done = t_r.done;

endmodule : seq_timer

// >>> verilog/flash_host_ctrl.sv
`timescale 1ns/1ns
`include "flash_host_regs.svh"
module flash_host_ctrl
    import flash_host_pkg::*;
#(
    parameter int SETUP_CYC  = `SETUP_CYC_DEF,
    parameter int ACCESS_CYC = `ACCESS_CYC_DEF,
    parameter int WE_CYC     = `WE_CYC_DEF,
    parameter int PROT_CYC   = `PROT_CYC_DEF,
    parameter int HOLD_CYC   = `HOLD_CYC_DEF
)
(
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic        cmd_valid,
    output logic             cmd_ready,
    input  wire op_t         cmd_op,
    input  wire logic [19:0] cmd_addr,
    input  wire logic [7:0]  cmd_wdata,
    output logic             rsp_valid,
    output logic [7:0]       rsp_data,
    output logic             rsp_err,
    output logic             chip_sel_n,
    output logic             out_gate_n,
    output logic             wr_strobe_n,
    output logic             dev_reset_n,
    output logic [19:0]      flash_addr,
    output logic [7:0]       dq_o,
    output logic             dq_oe,
    input  wire logic [7:0]  dq_i,
    output logic             elevated_select_voltage_line,
    output logic             elevated_select_voltage_gate
);
    localparam logic [15:0] WAKE_LOAD = 16'(`WAKE_CYC);

    host_state_t s_r;
    host_state_t s_nxt;
    logic        reading;

    seq_timer_if #(.CW(16)) tif ();

    seq_timer u_timer (
        .clk  (clk),
        .nrst (nrst),
        .tif  (tif)
    );

    assign reading = (s_r.op == OP_READ) || (s_r.op == OP_ID_HW) || (s_r.op == OP_PROT_CHECK);

    // bus sequencer: setup, strobe, hold, each timed by the shared timer
    always_comb begin
        s_nxt           = s_r;
        s_nxt.rsp_valid = 1'b0;
        tif.start       = 1'b0;
        tif.load        = 16'h0000;
        case (s_r.st)
            ST_IDLE: begin
                if (cmd_valid) begin
                    s_nxt.op       = cmd_op;
                    s_nxt.rsp_err  = 1'b0;
                    s_nxt.rsp_data = 8'h00;
                    if (cmd_op == OP_SLEEP) begin
                        s_nxt.dev_rst_n = 1'b0; // reset-only standby
                        s_nxt.asleep    = 1'b1;
                        s_nxt.rsp_valid = 1'b1;
                    end else if (cmd_op == OP_WAKE) begin
                        s_nxt.dev_rst_n = 1'b1;
                        tif.start       = 1'b1;
                        tif.load        = WAKE_LOAD;
                        s_nxt.st        = ST_WAKE;
                    end else if (s_r.asleep) begin
                        s_nxt.rsp_valid = 1'b1; // refused while the flash sleeps
                        s_nxt.rsp_err   = 1'b1;
                    end else begin
                        s_nxt.ce_n  = 1'b0;
                        s_nxt.wdata = cmd_wdata;
                        s_nxt.dq_oe = (cmd_op == OP_WRITE); // oe_n stays high
                        tif.start   = 1'b1;
                        tif.load    = 16'(SETUP_CYC);
                        s_nxt.st    = ST_SETUP;
                        if (cmd_op == OP_ID_HW) begin
                            s_nxt.addr               = '0; // query and aux low
                            s_nxt.addr[`ID_BYTE_BIT] = cmd_addr[0];
                            s_nxt.hv_line            = 1'b1;
                        end else if (cmd_op == OP_PROT_SET) begin
                            s_nxt.addr  = {cmd_addr[`GRP_W-1:0], 17'h00000};
                            s_nxt.hv_line = 1'b1;
                            s_nxt.hv_oe = 1'b1;
                        end else if (cmd_op == OP_PROT_CHECK) begin
                            s_nxt.addr  = {cmd_addr[`GRP_W-1:0], 17'h00000} | `VERIFY_LOW_ADDR;
                            s_nxt.hv_line = 1'b1;
                        end else begin
                            s_nxt.addr = cmd_addr;
                        end
                    end
                end
            end
            ST_SETUP: begin
                if (tif.done) begin
                    tif.start = 1'b1;
                    s_nxt.st  = ST_STROBE;
                    if (reading) begin
                        s_nxt.oe_n = 1'b0;
                        tif.load   = 16'(ACCESS_CYC);
                    end else begin
                        s_nxt.we_n = 1'b0; // select low, gate high
                        tif.load   = (s_r.op == OP_PROT_SET) ? 16'(PROT_CYC) : 16'(WE_CYC);
                    end
                end
            end
            ST_STROBE: begin
                if (tif.done) begin
                    s_nxt.oe_n = 1'b1;
                    s_nxt.we_n = 1'b1; // data still driven at the rising edge
                    if (reading) begin
                        s_nxt.rsp_data = dq_i;
                        s_nxt.rsp_err  = (s_r.op == OP_ID_HW) && !(^dq_i); // error on even parity
                    end
                    tif.start = 1'b1;
                    tif.load  = 16'(HOLD_CYC);
                    s_nxt.st  = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (tif.done) begin
                    s_nxt.ce_n      = 1'b1;
                    s_nxt.dq_oe     = 1'b0;
                    s_nxt.hv_line   = 1'b0;
                    s_nxt.hv_oe     = 1'b0; // elevated voltages held until here
                    s_nxt.rsp_valid = 1'b1;
                    s_nxt.st        = ST_IDLE;
                end
            end
            ST_WAKE: begin
                if (tif.done) begin
                    s_nxt.asleep    = 1'b0;
                    s_nxt.rsp_valid = 1'b1;
                    s_nxt.st        = ST_IDLE;
                end
            end
            default: begin
                s_nxt.st = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_r           <= '0;
            s_r.st        <= ST_IDLE;
            s_r.op        <= OP_READ;
            s_r.ce_n      <= 1'b1;
            s_r.oe_n      <= 1'b1;
            s_r.we_n      <= 1'b1;
            s_r.dev_rst_n <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    // outputs straight from the state flops, except cmd_ready, which is decoded from s_r.st
    assign cmd_ready                    = (s_r.st == ST_IDLE);
    assign rsp_valid                    = s_r.rsp_valid;
    assign rsp_data                     = s_r.rsp_data;
    assign rsp_err                      = s_r.rsp_err;
    assign chip_sel_n                   = s_r.ce_n;
    assign out_gate_n                   = s_r.oe_n;
    assign wr_strobe_n                  = s_r.we_n;
    assign dev_reset_n                  = s_r.dev_rst_n;
    assign flash_addr                   = s_r.addr;
    assign dq_o                         = s_r.wdata;
    assign dq_oe                        = s_r.dq_oe;
    assign elevated_select_voltage_line = s_r.hv_line;
    assign elevated_select_voltage_gate = s_r.hv_oe;

    // cycles since the flash reset was last released, saturating
    logic [15:0] awake_cnt_r;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            awake_cnt_r <= 16'hFFFF;
        end else if (!s_r.dev_rst_n) begin
            awake_cnt_r <= 16'h0000;
        end else if (awake_cnt_r != 16'hFFFF) begin
            awake_cnt_r <= awake_cnt_r + 16'h0001;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    AST_NO_CONTENTION: assert property (!(dq_oe && !out_gate_n))
        else $error("host drives data while output gate is low");
    AST_WAKE_WAIT: assert property ($fell(out_gate_n) |-> awake_cnt_r >= WAKE_LOAD)
        else $error("read started before wake-up time");
    AST_ID_HV: assert property ($fell(out_gate_n) && s_r.op == OP_ID_HW
        |-> elevated_select_voltage_line && !chip_sel_n)
        else $error("identifier read without elevated voltage");
    AST_ID_QUERY_LOW: assert property (!out_gate_n && s_r.op == OP_ID_HW
        |-> !flash_addr[`QUERY_BIT] && !flash_addr[`AUX_BIT])
        else $error("query select not low during identifier read");
    AST_WRITE_COMBO: assert property ($fell(wr_strobe_n) && !elevated_select_voltage_gate
        |-> !chip_sel_n && out_gate_n && dq_oe)
        else $error("command write with wrong strobe combination");
    AST_PROT_SETUP: assert property ($fell(wr_strobe_n) && s_r.op == OP_PROT_SET
        |-> elevated_select_voltage_line && elevated_select_voltage_gate && !chip_sel_n)
        else $error("protect pulse without elevated voltages");
    AST_PROT_ADDR_STABLE: assert property (!wr_strobe_n && $past(!wr_strobe_n)
        |-> flash_addr == $past(flash_addr))
        else $error("address moved during write strobe");
    AST_VERIFY_SETUP: assert property (!out_gate_n && s_r.op == OP_PROT_CHECK
        |-> elevated_select_voltage_line && wr_strobe_n && !chip_sel_n
            && flash_addr[6:0] == 7'h02)
        else $error("protection verify with wrong setup");

    COV_READ: cover property (s_r.op == OP_READ && rsp_valid);
    COV_WRITE: cover property (s_r.op == OP_WRITE && rsp_valid);
    COV_PROT: cover property (s_r.op == OP_PROT_SET && rsp_valid);
    COV_WAKE: cover property (s_r.op == OP_WAKE && rsp_valid);

endmodule : flash_host_ctrl

// >>> dv/flash_model.sv
`timescale 1ns/1ns
module flash_model #(
    parameter logic [7:0] MAKER_ID = 8'h13, // arbitrary value, odd parity
    parameter logic [7:0] PART_ID  = 8'h8A  // arbitrary value, odd parity
)(
    input  wire logic        chip_sel_n,
    input  wire logic        out_gate_n,
    input  wire logic        wr_strobe_n,
    input  wire logic        dev_reset_n,
    input  wire logic [19:0] addr,
    input  wire logic [7:0]  dq_o,
    input  wire logic        dq_oe,
    input  wire logic        hv_line,
    input  wire logic        hv_gate,
    output logic [7:0]       dq_i
);
    logic [7:0]  prot_r = 8'h00; // eight groups of two sectors, all open
    logic [1:0]  seq_r  = 2'h0;
    logic        auto_r = 1'h0;  // power up in array read
    logic        awake  = 1'h1;
    logic [19:0] wa_r   = 20'h00000;
    logic [7:0]  last_r = 8'h00;
    logic [7:0]  val;
    logic        drv;
    // drive only when selected, gated, out of reset and awake
    assign drv  = !chip_sel_n && !out_gate_n && dev_reset_n && awake;
    // released bus shows the inverse of the last value
    assign dq_i = drv ? val : ~last_r;
    always @(drv or val) if (drv) last_r = val;
    // reset-only standby, then the wake-up time
    always @(negedge dev_reset_n) begin
        awake = 1'h0;
        seq_r = 2'h0;
        auto_r = 1'h0;
        @(posedge dev_reset_n);
        #500 awake = 1'h1;
    end
    // id mode decodes only address bits 0 and 1 and the group lines 19:17
    always_comb begin
        if (hv_line || auto_r)
            val = !addr[1] ? (addr[0] ? PART_ID : MAKER_ID) : {7'h00, prot_r[addr[19:17]]};
        else
            val = addr[7:0] ^ addr[15:8];
    end
    // address on later falling edge, data on first rising edge
    always @(negedge wr_strobe_n) if (!chip_sel_n) wa_r = addr;
    always @(posedge wr_strobe_n) begin
        if (!chip_sel_n && hv_gate && hv_line && addr[19:17] == wa_r[19:17])
            prot_r[wa_r[19:17]] = 1'h1;
        else if (!chip_sel_n && out_gate_n && dq_oe && dev_reset_n) begin
            if (seq_r == 2'h0 && wa_r[10:0] == 11'h555 && dq_o == 8'hAA)
                seq_r = 2'h1;
            else if (seq_r == 2'h1 && wa_r[10:0] == 11'h2AA && dq_o == 8'h55)
                seq_r = 2'h2;
            else if (seq_r == 2'h2 && wa_r[10:0] == 11'h555 && dq_o == 8'h90) begin
                seq_r = 2'h0;
                auto_r = 1'h1;
            end else begin
                seq_r = 2'h0;
                auto_r = 1'h0;
            end
        end
    end
endmodule : flash_model

// >>> dv/testbench.sv
`timescale 1ns/1ns
module testbench
    import flash_host_pkg::*;
;
    localparam logic [7:0] MAKER = 8'h13; // arbitrary value, odd parity
    localparam logic [7:0] PART  = 8'h8A; // arbitrary value, odd parity
    logic clk = 1'h0, nrst = 1'h0, cmd_valid = 1'h0;
    op_t cmd_op = OP_READ;
    logic [19:0] cmd_addr = 20'h00000, fa;
    logic [7:0] cmd_wdata = 8'h00, rsp_data, dq_o, dq_i, rd;
    logic cmd_ready, rsp_valid, rsp_err, cs_n, og_n, ws_n, dr_n, dq_oe, hv9, hvg, re;
    int errors = 0, cmp_count = 0, cyc = 0;
    flash_host_ctrl #(.PROT_CYC(5)) flash_host_ctrl_i (.clk(clk), .nrst(nrst),
        .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
        .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_err(rsp_err),
        .chip_sel_n(cs_n), .out_gate_n(og_n), .wr_strobe_n(ws_n), .dev_reset_n(dr_n),
        .flash_addr(fa), .dq_o(dq_o), .dq_oe(dq_oe), .dq_i(dq_i),
        .elevated_select_voltage_line(hv9), .elevated_select_voltage_gate(hvg));
    flash_model #(.MAKER_ID(MAKER), .PART_ID(PART)) flash_model_i (.chip_sel_n(cs_n),
        .out_gate_n(og_n), .wr_strobe_n(ws_n), .dev_reset_n(dr_n), .addr(fa),
        .dq_o(dq_o), .dq_oe(dq_oe), .hv_line(hv9), .hv_gate(hvg), .dq_i(dq_i));
    // clock and hang guard
    always #5 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 6000) begin
            errors++;
            report_and_stop();
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // one request, held until taken, answer sampled mid-cycle
    task automatic op(input op_t o, input logic [19:0] a, input logic [7:0] w);
        @(posedge clk);
        cmd_op <= o;
        cmd_addr <= a;
        cmd_wdata <= w;
        cmd_valid <= 1'h1;
        do @(posedge clk); while (cmd_ready !== 1'h1);
        cmd_valid <= 1'h0;
        do @(negedge clk); while (rsp_valid !== 1'h1);
        rd = rsp_data;
        re = rsp_err;
    endtask : op
    task automatic unlock(input logic [7:0] c);
        op(OP_WRITE, 20'h00555, 8'hAA);
        op(OP_WRITE, 20'h002AA, 8'h55);
        op(OP_WRITE, 20'h00555, c);
    endtask : unlock
    task automatic t_read;
        op(OP_READ, 20'h3C15A, 8'h00);
        chk(rd, 8'h5A ^ 8'hC1);
        chk({7'h00, re}, 8'h00);
        $display("test read done");
    endtask : t_read
    task automatic t_hw_id;
        op(OP_ID_HW, 20'h00000, 8'h00);
        chk(rd, MAKER);
        chk({7'h00, re}, 8'h00);
        op(OP_ID_HW, 20'hFFFF3, 8'h00);
        chk(rd, PART);
        chk({7'h00, re}, 8'h00);
        $display("test hardware id done");
    endtask : t_hw_id
    task automatic t_auto;
        unlock(8'h90);
        op(OP_READ, 20'hFFF00, 8'h00);
        chk(rd, MAKER);
        op(OP_READ, 20'h00001, 8'h00);
        chk(rd, PART);
        op(OP_READ, 20'hC0002, 8'h00);
        chk(rd, 8'h00);
        op(OP_WRITE, 20'h00000, 8'hF0);
        op(OP_WRITE, 20'h00555, 8'hAA);
        op(OP_WRITE, 20'h00555, 8'h90);
        op(OP_READ, 20'h00000, 8'h00);
        chk(rd, 8'h00);
        $display("test autoselect done");
    endtask : t_auto
    task automatic t_protect;
        op(OP_PROT_SET, 20'h00005, 8'h00);
        op(OP_PROT_CHECK, 20'h00005, 8'h00);
        chk(rd, 8'h01);
        op(OP_PROT_CHECK, 20'h00004, 8'h00);
        chk(rd, 8'h00);
        unlock(8'h90);
        op(OP_READ, 20'hA0002, 8'h00);
        chk(rd, 8'h01);
        op(OP_WRITE, 20'h00000, 8'hF0);
        $display("test protect done");
    endtask : t_protect
    task automatic t_sleep;
        op(OP_SLEEP, 20'h00000, 8'h00);
        chk({7'h00, dr_n}, 8'h00);
        op(OP_READ, 20'h00000, 8'h00);
        chk({7'h00, re}, 8'h01);
        op(OP_WAKE, 20'h00000, 8'h00);
        op(OP_READ, 20'h01234, 8'h00);
        chk(rd, 8'h34 ^ 8'h12);
        chk({7'h00, re}, 8'h00);
        $display("test standby done");
    endtask : t_sleep
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : report_and_stop
    // reset, then the scenarios in turn
    initial begin
        repeat (10) @(posedge clk);
        nrst <= 1'h1;
        t_read();
        t_hw_id();
        t_auto();
        t_protect();
        t_sleep();
        report_and_stop();
    end
endmodule : testbench
